// >>> src/fep_params.svh
// Constants of the flash erase and block protection sequencer
// Notes on behaviour
// - The array is 64 KB, one contiguous program region.
// - Erase works on 1 KB blocks, each erased alone.
// - A finished block erase leaves every bit of the block at one.
// - Protection is set per 2 KB region, each region independent.
// - Read-only regions refuse every erase and program request.
// - Execute-only regions refuse erase and program; fetches still read.
// - Data and debugger reads of execute-only regions return no contents.
// - Permitted reads complete in one clock cycle, no wait states.
`ifndef FEP_PARAMS_SVH
`define FEP_PARAMS_SVH
`define FEP_ADDR_W      16
`define FEP_WORD_IDX_W  14
`define FEP_WORDS       16384
`define FEP_DATA_W      32
`define FEP_BLOCK_LSB   10
`define FEP_BLOCK_W     6
`define FEP_REGION_LSB  11
`define FEP_REGION_W    5
`define FEP_REGIONS     32
`define FEP_BLK_WORDS_W 8
`define FEP_ERASED_WORD 32'hffffffff
`endif

// >>> src/fep_pkg.sv
// Types shared by the flash sequencer modules
package fep_pkg;
    typedef enum logic [1:0] {
        FEP_IDLE  = 2'b00,
        FEP_ERASE = 2'b01
    } fep_state_t;
endpackage : fep_pkg

// >>> src/fep_array.sv
// Flash word array held in flip-flops
`include "fep_params.svh"
module fep_array
    import fep_pkg::*;
#(
    parameter int WORDS  = `FEP_WORDS,
    parameter int IDX_W  = `FEP_WORD_IDX_W,
    parameter int DATA_W = `FEP_DATA_W
) (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              arst_n_in,
    // Write port: set forces ones, otherwise bits may only clear
    input  wire logic              wr_en_in,
    input  wire logic              wr_set_in,
    input  wire logic [IDX_W-1:0]  wr_idx_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    // Read ports
    input  wire logic [IDX_W-1:0]  rd_a_idx_in,
    output logic      [DATA_W-1:0] rd_a_data_out,
    input  wire logic [IDX_W-1:0]  rd_b_idx_in,
    output logic      [DATA_W-1:0] rd_b_data_out
);
    logic [DATA_W-1:0] mem_reg [WORDS];

    // Reset stands in for a blank part: every cell erased
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_reg[i] <= `FEP_ERASED_WORD;
            end
        end else if (wr_en_in) begin
            if (wr_set_in) begin
                mem_reg[wr_idx_in] <= `FEP_ERASED_WORD;
            end else begin
                // Programming can only pull bits to zero
                mem_reg[wr_idx_in] <= mem_reg[wr_idx_in] & wr_data_in;
            end
        end
    end

    assign rd_a_data_out = mem_reg[rd_a_idx_in];
    assign rd_b_data_out = mem_reg[rd_b_idx_in];
endmodule : fep_array

// >>> src/fep_sequencer.sv
// Flash sequencer: protected reads, word program and block erase
`include "fep_params.svh"
module fep_sequencer
    import fep_pkg::*;
#(
    parameter int ADDR_W = `FEP_ADDR_W,
    parameter int DATA_W = `FEP_DATA_W
) (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              arst_n_in,
    // Protection settings, one bit per 2 KB region
    input  wire logic [31:0]       prot_ro_in,
    input  wire logic [31:0]       prot_xo_in,
    // Instruction fetch port
    input  wire logic              fetch_req_in,
    input  wire logic [ADDR_W-1:0] fetch_addr_in,
    output logic                   fetch_valid_out,
    output logic                   fetch_err_out,
    output logic      [DATA_W-1:0] fetch_data_out,
    // Data read port, shared by processor data side and debugger
    input  wire logic              dread_req_in,
    input  wire logic              dread_dbg_in,
    input  wire logic [ADDR_W-1:0] dread_addr_in,
    output logic                   dread_valid_out,
    output logic                   dread_err_out,
    output logic      [DATA_W-1:0] dread_data_out,
    // Modify port: erase or word program
    input  wire logic              cmd_req_in,
    input  wire logic              cmd_erase_in,
    input  wire logic [ADDR_W-1:0] cmd_addr_in,
    input  wire logic [DATA_W-1:0] cmd_wdata_in,
    output logic                   cmd_busy_out,
    output logic                   cmd_done_out,
    output logic                   cmd_err_out
);
    if (ADDR_W != `FEP_ADDR_W || DATA_W != `FEP_DATA_W) begin : g_bad_cfg
        $error("fep_sequencer: only a 64 KB array of 32-bit words is served");
    end

    typedef struct packed {
        fep_state_t                   state;
        logic [`FEP_BLOCK_W-1:0]      blk;
        logic [`FEP_BLK_WORDS_W-1:0]  cnt;
        logic                         busy;
        logic                         done;
        logic                         cerr;
        logic                         fvalid;
        logic                         ferr;
        logic [31:0]                  fdata;
        logic                         dvalid;
        logic                         derr;
        logic [31:0]                  ddata;
    } fep_regs_t;

    fep_regs_t state_reg;
    fep_regs_t state_next;

    logic                        wr_en;
    logic                        wr_set;
    logic [`FEP_WORD_IDX_W-1:0]  wr_idx;
    logic [31:0]                 fetch_word;
    logic [31:0]                 data_word;

    function automatic logic [`FEP_REGION_W-1:0] region_of(
        input logic [`FEP_ADDR_W-1:0] addr
    );
        return addr[`FEP_ADDR_W-1:`FEP_REGION_LSB];
    endfunction : region_of

    function automatic logic [`FEP_WORD_IDX_W-1:0] word_of(
        input logic [`FEP_ADDR_W-1:0] addr
    );
        return addr[`FEP_ADDR_W-1:2];
    endfunction : word_of

    fep_array u_array (
        .clock_in      (clock_in),
        .arst_n_in     (arst_n_in),
        .wr_en_in      (wr_en),
        .wr_set_in     (wr_set),
        .wr_idx_in     (wr_idx),
        .wr_data_in    (cmd_wdata_in),
        .rd_a_idx_in   (word_of(fetch_addr_in)),
        .rd_a_data_out (fetch_word),
        .rd_b_idx_in   (word_of(dread_addr_in)),
        .rd_b_data_out (data_word)
    );

    always_comb begin
        logic locked;
        locked = 1'b0;
        state_next = state_reg;
        wr_en = 1'b0;
        wr_set = 1'b0;
        wr_idx = word_of(cmd_addr_in);
        state_next.done = 1'b0;
        state_next.cerr = 1'b0;

        // Fetches read every region, execute-only included
        state_next.fvalid = fetch_req_in;
        state_next.ferr = 1'b0;
        state_next.fdata = fetch_req_in ? fetch_word : 32'h00000000;

        // Data side sees zeros, not contents, on an execute-only region
        state_next.dvalid = dread_req_in;
        state_next.derr = 1'b0;
        state_next.ddata = 32'h00000000;
        if (dread_req_in) begin
            if (prot_xo_in[region_of(dread_addr_in)]) begin
                state_next.derr = 1'b1;
            end else begin
                state_next.ddata = data_word;
            end
        end

        case (state_reg.state)
            FEP_IDLE: begin
                if (cmd_req_in) begin
                    // Either protection kind locks the region against change
                    locked = prot_ro_in[region_of(cmd_addr_in)]
                        | prot_xo_in[region_of(cmd_addr_in)];
                    if (locked) begin
                        state_next.cerr = 1'b1;
                        state_next.done = 1'b1;
                    end else if (cmd_erase_in) begin
                        state_next.state = FEP_ERASE;
                        state_next.busy = 1'b1;
                        state_next.blk =
                            cmd_addr_in[`FEP_ADDR_W-1:`FEP_BLOCK_LSB];
                        state_next.cnt = '0;
                    end else begin
                        wr_en = 1'b1;
                        state_next.done = 1'b1;
                    end
                end
            end
            FEP_ERASE: begin
                // One word per cycle; only the latched block is touched
                wr_en = 1'b1;
                wr_set = 1'b1;
                wr_idx = {state_reg.blk, state_reg.cnt};
                state_next.cnt = state_reg.cnt + 1'b1;
                if (&state_reg.cnt) begin
                    state_next.state = FEP_IDLE;
                    state_next.busy = 1'b0;
                    state_next.done = 1'b1;
                end
            end
            default: begin
                state_next.state = FEP_IDLE;
                state_next.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= '{state: FEP_IDLE, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign fetch_valid_out = state_reg.fvalid;
    assign fetch_err_out   = state_reg.ferr;
    assign fetch_data_out  = state_reg.fdata;
    assign dread_valid_out = state_reg.dvalid;
    assign dread_err_out   = state_reg.derr;
    assign dread_data_out  = state_reg.ddata;
    assign cmd_busy_out    = state_reg.busy;
    assign cmd_done_out    = state_reg.done;
    assign cmd_err_out     = state_reg.cerr;
endmodule : fep_sequencer

// >>> verif/fep_checker.sv
// Assertion checker for the flash sequencer ports
module fep_checker (
    // Observed ports
    input wire logic        clock_in, arst_n_in, fetch_req_in,
    input wire logic        fetch_valid_out, fetch_err_out, dread_req_in,
    input wire logic        dread_valid_out, dread_err_out, cmd_req_in,
    input wire logic        cmd_erase_in, cmd_busy_out, cmd_done_out,
    input wire logic        cmd_err_out,
    input wire logic [15:0] dread_addr_in, cmd_addr_in,
    input wire logic [31:0] prot_ro_in, prot_xo_in, dread_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    logic take, hit, rxo;
    assign take = cmd_req_in && !cmd_busy_out;
    assign hit = prot_ro_in[cmd_addr_in[15:11]]
               | prot_xo_in[cmd_addr_in[15:11]];
    assign rxo = prot_xo_in[dread_addr_in[15:11]];
    sequence s_go;
        take && cmd_erase_in && !hit;
    endsequence
    // Busy is checked at both ends of the 256 word walk only
    sequence s_end;
        cmd_busy_out[*8] ##248 cmd_busy_out ##1 cmd_done_out && !cmd_busy_out;
    endsequence
    AST_FETCH: assert property (fetch_req_in |=> fetch_valid_out && !fetch_err_out)
        else $error("fetch answer");
    AST_IDLE: assert property (!fetch_req_in |=> !fetch_valid_out)
        else $error("fetch idle");
    AST_DREAD: assert property (dread_req_in && !rxo |=> !dread_err_out)
        else $error("read refused");
    AST_XO: assert property (dread_req_in && rxo |=> dread_err_out && dread_data_out == 32'h0)
        else $error("hidden read");
    AST_REFUSE: assert property (take && hit |=> cmd_err_out && !cmd_busy_out)
        else $error("refusal");
    AST_PROG: assert property (take && !cmd_erase_in && !hit |=> cmd_done_out && !cmd_err_out)
        else $error("program");
    AST_ERASE: assert property (s_go |=> s_end)
        else $error("erase timing");
    AST_ERR_DONE: assert property (cmd_err_out |-> cmd_done_out)
        else $error("err without done");
endmodule : fep_checker
bind fep_sequencer fep_checker u_chk (.*);

// >>> verif/fep_host_model.sv
// Far side model: processor fetch and data or debugger read requester
module fep_host_model (
    // Clock, requests, answers
    input  wire logic        clock_in, fetch_valid_out, dread_valid_out,
    input  wire logic        dread_err_out,
    input  wire logic [31:0] fetch_data_out, dread_data_out,
    output logic             fetch_req_in = 1'b0, dread_req_in = 1'b0,
    output logic             dread_dbg_in = 1'b0,
    output logic      [15:0] fetch_addr_in = 16'h0, dread_addr_in = 16'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released address shows its inverse so a stale value cannot pass
    task automatic rd(input logic f, input logic [15:0] a, input logic g,
                      output logic v, output logic e, output logic [31:0] d);
        @(posedge clock_in);
        #1;
        {fetch_req_in, dread_req_in, dread_dbg_in} = {f, !f, g};
        {fetch_addr_in, dread_addr_in} = {a, a};
        @(posedge clock_in);
        #1;
        {fetch_req_in, dread_req_in} = 2'h0;
        {fetch_addr_in, dread_addr_in} = {~a, ~a};
        v = f ? fetch_valid_out : dread_valid_out;
        e = f ? 1'b0 : dread_err_out;
        d = f ? fetch_data_out : dread_data_out;
    endtask : rd
endmodule : fep_host_model

// >>> verif/fep_sequencer_tb_top.sv
// Self-checking testbench for the flash sequencer
module fep_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in = 1'b0, arst_n_in = 1'b0, cmd_req_in = 1'b0;
    logic        cmd_erase_in = 1'b0, v, e, fetch_req_in, dread_req_in;
    logic        dread_dbg_in, fetch_valid_out, fetch_err_out, cmd_err_out;
    logic        dread_valid_out, dread_err_out, cmd_busy_out, cmd_done_out;
    logic [15:0] cmd_addr_in = 16'h0, fetch_addr_in, dread_addr_in;
    logic [31:0] prot_ro_in = 32'h0, prot_xo_in = 32'h0, cmd_wdata_in = 32'h0;
    logic [31:0] fetch_data_out, dread_data_out, d;
    int          n_errors = 0, tests_run = 0;
    fep_sequencer DUT (.*);
    fep_host_model host (.*);
    always #25 clock_in = ~clock_in;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compares %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic cm(input logic r, input logic [15:0] a,
                      input logic [31:0] w, input logic bad);
        int n;
        @(posedge clock_in);
        #1;
        {cmd_req_in, cmd_erase_in, cmd_addr_in, cmd_wdata_in} = {1'b1, r, a, w};
        @(posedge clock_in);
        #1;
        {cmd_req_in, cmd_addr_in} = {1'b0, ~a};
        for (n = 1; n < 300 && cmd_done_out !== 1'b1; n++) @(posedge clock_in) #1;
        if (n == 300) begin
            n_errors++;
            give_verdict();
        end
        chk({31'h0, cmd_err_out}, {31'h0, bad});
        chk(n, (r && !bad) ? 32'h101 : 32'h1);
    endtask : cm
    task automatic rc(input logic f, input logic [15:0] a, input logic g,
                      input logic xe, input logic [31:0] xd);
        host.rd(f, a, g, v, e, d);
        chk({31'h0, v}, 32'h1);
        chk({31'h0, e}, {31'h0, xe});
        chk(d, xd);
    endtask : rc
    task automatic s_program;
        cm(0, 16'h0, 32'h12345678, 0);
        cm(0, 16'hfffc, 32'h0f0f0f0f, 0);
        cm(0, 16'hfffc, 32'hff00ff00, 0);
        rc(0, 16'h0, 0, 0, 32'h12345678);
        rc(1, 16'hfffc, 0, 0, 32'h0f000f00);
    endtask : s_program
    task automatic s_protect;
        prot_ro_in = 32'h1;
        cm(0, 16'h4, 32'h0, 1);
        cm(1, 16'h400, 32'h0, 1);
        cm(0, 16'h800, 32'h0, 0);
        rc(0, 16'h4, 1, 0, 32'hffffffff);
        rc(0, 16'h800, 0, 0, 32'h0);
        {prot_ro_in, prot_xo_in} = {32'h0, 32'h1};
        cm(1, 16'h0, 32'h0, 1);
        rc(1, 16'h0, 0, 0, 32'h12345678);
        rc(0, 16'h0, 0, 1, 32'h0);
        rc(0, 16'h0, 1, 1, 32'h0);
        prot_xo_in = 32'h0;
    endtask : s_protect
    task automatic s_erase;
        cm(0, 16'h400, 32'h0, 0);
        cm(0, 16'h3fc, 32'h0, 0);
        cm(1, 16'h10, 32'h0, 0);
        rc(0, 16'h0, 0, 0, 32'hffffffff);
        rc(0, 16'h3fc, 0, 0, 32'hffffffff);
        rc(0, 16'h400, 0, 0, 32'h0);
    endtask : s_erase
    initial begin
        repeat (10) @(posedge clock_in);
        #1;
        arst_n_in = 1'b1;
        s_program();
        s_protect();
        s_erase();
        give_verdict();
    end
endmodule : fep_sequencer_tb_top
